// [shared/dcc_cfg.svh]
// register map, field positions, reset values and mode encodings of the dma channel control
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DCC_OFS_CMD      8'h00
`define DCC_OFS_MODE_WR  8'h04
`define DCC_OFS_REQ      8'h08
`define DCC_OFS_MASK     8'h0C
`define DCC_OFS_CFG      8'h10
`define DCC_OFS_HWREQ    8'h14
`define DCC_OFS_MODE0    8'h20
`define DCC_OFS_MODE3    8'h2C
// ----------------------------------------------------------------
// command fields
// ----------------------------------------------------------------
`define DCC_CMD_DACK_HI  7
`define DCC_CMD_DREQ_HI  6
`define DCC_CMD_EXT_WR   5
`define DCC_CMD_ROTATE   4
`define DCC_CMD_NORMAL   3
`define DCC_CMD_DISABLE  2
`define DCC_CMD_ADDR_HLD 1
`define DCC_CMD_MEM2MEM  0
`define DCC_CMD_RESET    8'h08
// ----------------------------------------------------------------
// mode, request, mask and config fields
// ----------------------------------------------------------------
`define DCC_MODE_XM_HI   7
`define DCC_MODE_XM_LO   6
`define DCC_MODE_DEC     5
`define DCC_MODE_AUTO    4
`define DCC_MODE_TT_HI   3
`define DCC_MODE_TT_LO   2
`define DCC_MODE_RESET   8'h00
`define DCC_SEL_HI       1
`define DCC_SEL_LO       0
`define DCC_SETBIT       2
`define DCC_RD_ONES      4'hF
`define DCC_SEL_ONES     2'h3
`define DCC_CFG_CLKSEL   0
`define DCC_CFG_WS_HI    3
`define DCC_CFG_WS_LO    2
`define DCC_CFG_RESET    8'h00
`define DCC_XM_DEMAND    2'h0
`define DCC_XM_SINGLE    2'h1
`define DCC_XM_BLOCK     2'h2
`define DCC_XM_CASCADE   2'h3
`define DCC_TT_VERIFY    2'h0
`define DCC_TT_WRITE     2'h1
`define DCC_TT_READ      2'h2
`endif

// [shared/dcc_pkg.sv]
// types shared by the dma channel control
package dcc_pkg;
  typedef enum logic [2:0] {
    DCC_IDLE,
    DCC_S1,
    DCC_S2,
    DCC_S3,
    DCC_S4,
    DCC_CASC
  } dcc_state_t;
endpackage

// [logic/dcc_channel_ctrl.sv]
// dma channel control: apb registers, arbitration, cycle sequencer and strobes
`timescale 1ns/1ps
`include "dcc_cfg.svh"
module dcc_channel_ctrl
  import dcc_pkg::*;
#(
  parameter int NCH = 4,
  parameter int WSW = 2
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [NCH-1:0]   dreq,
  input  wire logic             iochrdy,
  input  wire logic             end_of_block,
  output logic      [NCH-1:0]   dack,
  output logic                  io_rd_n,
  output logic                  io_wr_n,
  output logic                  mem_rd_n,
  output logic                  mem_wr_n,
  output logic                  addr_step,
  output logic                  addr_dec,
  output logic      [1:0]       addr_ch,
  output logic                  autoinit_en,
  output logic                  dma_tick
);
  initial begin
    if (NCH != 4) $error("dcc_channel_ctrl serves exactly four channels");
    if (WSW < 2) $error("wait state field needs at least two bits");
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]     cmd_r;
  logic [7:0]     mode_r [NCH];
  logic [7:0]     cfg_r;
  logic [NCH-1:0] mask_r;
  logic [NCH-1:0] sreq_r;
  logic [31:0]    prdata_r;
  logic           pslverr_r;
  logic [31:0]    rd_nxt;
  logic           hit_nxt;

  wire wr_acc   = psel & penable & pwrite & ce;
  wire setup_rd = psel & ~penable & ~pwrite & ce;
  wire [1:0] wsel = pwdata[`DCC_SEL_HI:`DCC_SEL_LO];
  wire wset      = pwdata[`DCC_SETBIT];

  assign pready  = psel & penable;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r & psel & penable;

  // ----------------------------------------------------------------
  // request qualification
  // ----------------------------------------------------------------
  logic [NCH-1:0] hw_req;
  logic [NCH-1:0] pend;
  assign hw_req = cmd_r[`DCC_CMD_DREQ_HI] ? dreq : ~dreq;
  assign pend   = (hw_req & ~mask_r) | sreq_r;

  // read decode; prdata is latched in the setup cycle so it leaves a flop
  always_comb begin
    rd_nxt  = '0;
    hit_nxt = 1'b1;
    if (paddr == `DCC_OFS_CMD) begin
      rd_nxt[7:0] = cmd_r;
    end else if (paddr == `DCC_OFS_REQ) begin
      rd_nxt[7:0] = {`DCC_RD_ONES, sreq_r};
    end else if (paddr == `DCC_OFS_MASK) begin
      rd_nxt[7:0] = {`DCC_RD_ONES, mask_r};
    end else if (paddr == `DCC_OFS_CFG) begin
      rd_nxt[7:0] = cfg_r;
    end else if (paddr == `DCC_OFS_HWREQ) begin
      rd_nxt[7:0] = {`DCC_RD_ONES, hw_req};
    end else if (paddr == `DCC_OFS_MODE_WR) begin
      rd_nxt = '0;
    end else if (paddr >= `DCC_OFS_MODE0 && paddr <= `DCC_OFS_MODE3 && paddr[1:0] == 2'h0) begin
      rd_nxt[7:0] = {mode_r[paddr[3:2]][7:2], `DCC_SEL_ONES};
    end else begin
      hit_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (ce && psel && !penable) begin
      prdata_r  <= setup_rd ? rd_nxt : 32'h0000_0000;
      pslverr_r <= ~hit_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= `DCC_CMD_RESET;
      cfg_r <= `DCC_CFG_RESET;
    end else if (wr_acc && paddr == `DCC_OFS_CMD) begin
      cmd_r <= pwdata[7:0];
    end else if (wr_acc && paddr == `DCC_OFS_CFG) begin
      cfg_r <= pwdata[7:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_mode
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mode_r[g] <= `DCC_MODE_RESET;
        end else if (wr_acc && paddr == `DCC_OFS_MODE_WR && wsel == 2'(g)) begin
          mode_r[g] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= '1;
    end else if (wr_acc && paddr == `DCC_OFS_MASK) begin
      mask_r[wsel] <= wset;
    end
  end

  // ----------------------------------------------------------------
  // dma tick: halved or direct, switched only at a slow-period edge
  // ----------------------------------------------------------------
  logic half_r;
  logic sel_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_r <= 1'b0;
      sel_r  <= 1'b0;
    end else if (ce) begin
      half_r <= sel_r ? 1'b0 : ~half_r;
      if (sel_r || half_r) begin
        sel_r <= cfg_r[`DCC_CFG_CLKSEL];
      end
    end
  end
  assign dma_tick = ce & (sel_r | half_r);
  wire adv = dma_tick;

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  logic [1:0] base_r;
  logic [1:0] pick;
  logic       pick_ok;
  always_comb begin
    logic [1:0] c;
    c       = 2'h0;
    pick    = 2'h0;
    pick_ok = 1'b0;
    for (int i = NCH - 1; i >= 0; i--) begin
      c = cmd_r[`DCC_CMD_ROTATE] ? 2'(base_r + 2'(i)) : 2'(i);
      if (pend[c]) begin
        pick    = c;
        pick_ok = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  dcc_state_t     st_r;
  logic [1:0]     ch_r;
  logic           m2m_r;
  logic           m2m_ph_r;
  logic [WSW-1:0] ws_r;
  logic [1:0]     cur_xm;
  logic [1:0]     cur_tt;
  logic           more;
  assign cur_xm = mode_r[ch_r][`DCC_MODE_XM_HI:`DCC_MODE_XM_LO];
  assign cur_tt = mode_r[ch_r][`DCC_MODE_TT_HI:`DCC_MODE_TT_LO];

  wire start_m2m = cmd_r[`DCC_CMD_MEM2MEM] & sreq_r[0];
  wire can_run   = ~cmd_r[`DCC_CMD_DISABLE];

  always_comb begin
    unique case (cur_xm)
      `DCC_XM_DEMAND: more = pend[ch_r];
      `DCC_XM_BLOCK:  more = ~end_of_block;
      default:        more = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r     <= DCC_IDLE;
      ch_r     <= 2'h0;
      m2m_r    <= 1'b0;
      m2m_ph_r <= 1'b0;
      ws_r     <= '0;
    end else if (adv) begin
      unique case (st_r)
        DCC_IDLE: begin
          if (can_run && start_m2m) begin
            st_r     <= DCC_S1;
            ch_r     <= 2'h0;
            m2m_r    <= 1'b1;
            m2m_ph_r <= 1'b0;
          end else if (can_run && pick_ok) begin
            ch_r  <= pick;
            m2m_r <= 1'b0;
            st_r  <= (mode_r[pick][`DCC_MODE_XM_HI:`DCC_MODE_XM_LO] == `DCC_XM_CASCADE)
                     ? DCC_CASC : DCC_S1;
          end
        end
        DCC_S1: begin
          st_r <= DCC_S2;
          ws_r <= WSW'(cfg_r[`DCC_CFG_WS_HI:`DCC_CFG_WS_LO]);
        end
        DCC_S2: begin
          // compressed timing drops the wait state unless the bus holds off
          st_r <= (cmd_r[`DCC_CMD_NORMAL] || !iochrdy) ? DCC_S3 : DCC_S4;
        end
        DCC_S3: begin
          if (ws_r != '0) begin
            ws_r <= ws_r - 1'b1;
          end else if (iochrdy) begin
            st_r <= DCC_S4;
          end
        end
        DCC_S4: begin
          if (m2m_r && !m2m_ph_r) begin
            m2m_ph_r <= 1'b1;
            ch_r     <= 2'h1;
            st_r     <= DCC_S1;
          end else if (!m2m_r && more && can_run) begin
            st_r <= DCC_S1;
          end else begin
            st_r     <= DCC_IDLE;
            m2m_r    <= 1'b0;
            m2m_ph_r <= 1'b0;
          end
        end
        DCC_CASC: begin
          if (!pend[ch_r]) begin
            st_r <= DCC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_r <= 2'h0;
    end else if (adv && st_r == DCC_S4 && !m2m_r) begin
      base_r <= 2'(ch_r + 2'h1);
    end
  end

  // soft requests: a new set wins over the clear at end of service
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sreq_r <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_acc && paddr == `DCC_OFS_REQ && wset && wsel == 2'(i)) begin
          sreq_r[i] <= 1'b1;
        end else if (adv && st_r == DCC_S4 && ch_r == 2'(i) && !(m2m_r && !m2m_ph_r)) begin
          sreq_r[i] <= 1'b0;
        end else if (adv && st_r == DCC_S4 && m2m_r && m2m_ph_r && i == 0) begin
          sreq_r[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // strobes and acknowledges (registered)
  // ----------------------------------------------------------------
  logic [NCH-1:0] ack_r;
  logic rd_on;
  logic wr_on;
  logic io_rd_r;
  logic io_wr_r;
  logic mem_rd_r;
  logic mem_wr_r;
  logic step_r;
  dcc_state_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (adv) begin
      unique case (st_r)
        DCC_S1:  st_nxt = DCC_S2;
        DCC_S2:  st_nxt = (cmd_r[`DCC_CMD_NORMAL] || !iochrdy) ? DCC_S3 : DCC_S4;
        DCC_S3:  st_nxt = (ws_r == '0 && iochrdy) ? DCC_S4 : DCC_S3;
        default: st_nxt = st_r;
      endcase
    end
  end
  assign rd_on = (st_nxt == DCC_S2) || (st_nxt == DCC_S3);
  // extended write opens the write strobe together with the read strobe;
  // compressed timing has no s3 to host a late write, so it opens early too
  assign wr_on = (st_nxt == DCC_S3)
                 || ((cmd_r[`DCC_CMD_EXT_WR] || !cmd_r[`DCC_CMD_NORMAL])
                     && st_nxt == DCC_S2);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_rd_r  <= 1'b0;
      io_wr_r  <= 1'b0;
      mem_rd_r <= 1'b0;
      mem_wr_r <= 1'b0;
    end else if (ce) begin
      if (m2m_r) begin
        io_rd_r  <= 1'b0;
        io_wr_r  <= 1'b0;
        mem_rd_r <= rd_on & ~m2m_ph_r;
        mem_wr_r <= wr_on & m2m_ph_r;
      end else begin
        io_rd_r  <= rd_on & (cur_tt == `DCC_TT_WRITE);
        mem_wr_r <= wr_on & (cur_tt == `DCC_TT_WRITE);
        mem_rd_r <= rd_on & (cur_tt == `DCC_TT_READ);
        io_wr_r  <= wr_on & (cur_tt == `DCC_TT_READ);
      end
    end
  end
  assign io_rd_n  = ~io_rd_r;
  assign io_wr_n  = ~io_wr_r;
  assign mem_rd_n = ~mem_rd_r;
  assign mem_wr_n = ~mem_wr_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= '0;
    end else if (ce) begin
      for (int i = 0; i < NCH; i++) begin
        ack_r[i] <= !m2m_r && ch_r == 2'(i) && st_nxt != DCC_IDLE && st_nxt != DCC_S4
                    && (st_r != DCC_IDLE || adv);
      end
    end
  end
  assign dack = cmd_r[`DCC_CMD_DACK_HI] ? ack_r : ~ack_r;

  // address step request to the address counters, one cycle per transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_r      <= 1'b0;
      addr_ch     <= 2'h0;
      addr_dec    <= 1'b0;
      autoinit_en <= 1'b0;
    end else if (ce) begin
      step_r      <= adv && st_r == DCC_S4 && st_nxt == DCC_S4
                     && !(m2m_r && !m2m_ph_r && cmd_r[`DCC_CMD_ADDR_HLD]);
      addr_ch     <= ch_r;
      addr_dec    <= mode_r[ch_r][`DCC_MODE_DEC];
      autoinit_en <= mode_r[ch_r][`DCC_MODE_AUTO];
    end
  end
  assign addr_step = step_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  dack_polarity_a: assert property (cmd_r[`DCC_CMD_DACK_HI] |-> dack == ack_r)
    else $error("dack polarity wrong");
  dreq_polarity_a: assert property (!cmd_r[`DCC_CMD_DREQ_HI] |-> hw_req == ~dreq)
    else $error("dreq polarity wrong");
  ext_write_a: assert property ($rose(io_rd_r) && cmd_r[`DCC_CMD_EXT_WR] && !$past(psel)
    |-> mem_wr_r)
    else $error("extended write strobe late");
  disable_idle_a: assert property (st_r == DCC_IDLE && cmd_r[`DCC_CMD_DISABLE] && ce
    |=> st_r == DCC_IDLE)
    else $error("cycle started while disabled");
  req_read_a: assert property (setup_rd && paddr == `DCC_OFS_REQ
    |=> prdata[7:4] == 4'hF && prdata[3:0] == $past(sreq_r))
    else $error("request read wrong");
  mode_read_a: assert property (setup_rd && paddr == `DCC_OFS_MODE0 |=> prdata[1:0] == 2'h3)
    else $error("mode read select bits not ones");
  mask_set_a: assert property (wr_acc && paddr == `DCC_OFS_MASK && wset
    |=> mask_r[$past(wsel)])
    else $error("mask not set");
  mask_clr_a: assert property (wr_acc && paddr == `DCC_OFS_MASK && !wset
    |=> !mask_r[$past(wsel)])
    else $error("mask not cleared");
  soft_req_a: assert property (wr_acc && paddr == `DCC_OFS_REQ && wset
    |=> sreq_r[$past(wsel)])
    else $error("soft request lost");
  ready_wait_a: assert property (st_r == DCC_S3 && ws_r == '0 && !iochrdy && ce
    |=> st_r == DCC_S3)
    else $error("cycle ended while not ready");
  tick_rate_a: assert property (ce && !sel_r && !cfg_r[`DCC_CFG_CLKSEL] && dma_tick
    |=> !dma_tick || !ce)
    else $error("halved tick too fast");

  cov_cascade_c: cover property (st_r == DCC_CASC);
  cov_m2m_c:     cover property (m2m_r && m2m_ph_r && mem_wr_r);
  cov_wait_c:    cover property (st_r == DCC_S3 && !iochrdy);
  cov_rotate_c:  cover property (cmd_r[`DCC_CMD_ROTATE] && addr_step);
endmodule

// [testbench/dcc_periph_model.sv]
// behavioural model of the peripherals on the request / acknowledge side
`timescale 1ns/1ps
// ----------------------------------------------------------------
// peripheral model
// ----------------------------------------------------------------
module dcc_periph_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] want,
  input  wire logic       pol_hi,
  input  wire logic [3:0] dack,
  input  wire logic       stall,
  output logic      [3:0] dreq,
  output logic            iochrdy
);
  logic [3:0] served_r;
  logic [3:0] ack_seen;
  logic [1:0] hold_r;
  // the acknowledge level follows the same polarity choice as the request
  assign ack_seen = pol_hi ? dack : ~dack;
  // a peripheral drops its request once it has been acknowledged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      served_r <= 4'h0;
    end else begin
      served_r <= (served_r | ack_seen) & want;
    end
  end
  // request level obeys the programmed polarity
  assign dreq    = pol_hi ? (want & ~served_r) : ~(want & ~served_r);
  // a slow peripheral holds the bus not ready for three cycles once acknowledged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= 2'h0;
    end else if (stall && |(ack_seen & ~served_r & want)) begin
      hold_r <= 2'h3;
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end
  end
  assign iochrdy = (hold_r == 2'h0);
endmodule

// [testbench/testbench.sv]
// self-checking testbench of the dma channel control
`timescale 1ns/1ps
`include "dcc_cfg.svh"
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  dreq;
  logic        iochrdy;
  logic [3:0]  dack;
  logic        io_rd_n, io_wr_n, mem_rd_n, mem_wr_n;
  logic        addr_step, addr_dec, autoinit_en, dma_tick;
  logic [1:0]  addr_ch;
  logic [3:0]  want = 4'h0;
  logic        pol_hi = 1'b0;
  logic        stall = 1'b0;
  logic        eob = 1'b0;
  int          t_rd_end = 0;
  int          n_mrd = 0;
  int          n_iow = 0;
  logic [31:0] rd;
  logic        err;
  logic        st_dec, st_auto;
  logic [1:0]  st_ch;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          t_rd = 0;
  int          t_wr = 0;
  int          n_tick = 0;
  int          n_step = 0;
  always #4 pclk = ~pclk;
  dcc_channel_ctrl uut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dreq(dreq), .iochrdy(iochrdy), .end_of_block(eob), .dack(dack),
    .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n),
    .addr_step(addr_step), .addr_dec(addr_dec), .addr_ch(addr_ch),
    .autoinit_en(autoinit_en), .dma_tick(dma_tick)
  );
  dcc_periph_model periph (
    .pclk(pclk), .presetn(presetn), .want(want), .pol_hi(pol_hi), .dack(dack),
    .stall(stall), .dreq(dreq), .iochrdy(iochrdy)
  );
  // ----------------------------------------------------------------
  // monitor and timeout
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if ($fell(io_rd_n)) t_rd <= cyc;
    if ($fell(mem_wr_n)) t_wr <= cyc;
    if ($rose(io_rd_n)) t_rd_end <= cyc;
    if ($fell(mem_rd_n)) n_mrd <= n_mrd + 1;
    if ($fell(io_wr_n)) n_iow <= n_iow + 1;
    if (dma_tick === 1'b1) n_tick <= n_tick + 1;
    if (addr_step === 1'b1) begin
      n_step  <= n_step + 1;
      st_dec  <= addr_dec;
      st_ch   <= addr_ch;
      st_auto <= autoinit_en;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("mismatches %0d of %0d comparisons", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // pready is sampled at the edge; request held until then
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // channels are reprogrammed only with the controller disabled
  task automatic prog_mode(input logic [7:0] m, input logic [7:0] cmdv);
    apb(1'b1, `DCC_OFS_CMD, {24'h0, cmdv | 8'h04});
    apb(1'b1, `DCC_OFS_MODE_WR, {24'h0, m});
    apb(1'b1, `DCC_OFS_CMD, {24'h0, cmdv});
  endtask
  // poll until every soft request has been served
  task automatic drain();
    int k;
    k = 0;
    do begin
      apb(1'b0, `DCC_OFS_REQ, 0);
      k++;
    end while (rd !== 32'hF0 && k < 40);
    check(rd, 32'hF0);
  endtask
  task automatic serve(input int c, input logic [3:0] exp, input logic [3:0] idle);
    int k;
    int s0;
    s0 = n_step;
    want[c] <= 1'b1;
    k = 0;
    while (dack === idle && k < 60) begin @(posedge pclk); k++; end
    check(dack, exp);
    k = 0;
    while (n_step == s0 && k < 60) begin @(posedge pclk); k++; end
    want[c] <= 1'b0;
    wait_cyc(3);
    check(n_step - s0, 1);
    check(st_ch, c[1:0]);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check(dack, 4'hF);
    apb(1'b0, `DCC_OFS_CMD, 0);
    check(rd, 32'h08);
    apb(1'b0, `DCC_OFS_REQ, 0);
    check(rd, 32'hF0);
    apb(1'b0, `DCC_OFS_MASK, 0);
    check(rd, 32'hFF);
  endtask
  task automatic t_regs();
    logic [7:0] m;
    int s;
    for (int c = 0; c < 4; c++) begin
      m = {c[1:0], 1'b0, c[0], (c == 3) ? 2'h0 : c[1:0], c[1:0]};
      apb(1'b1, `DCC_OFS_MODE_WR, {24'h0, m});
      apb(1'b0, `DCC_OFS_MODE0 + 8'(4 * c), 0);
      check(rd, {24'h0, m[7:2], 2'h3});
    end
    apb(1'b1, `DCC_OFS_CMD, 32'h0C);
    apb(1'b1, `DCC_OFS_REQ, 32'hFE);
    apb(1'b1, `DCC_OFS_REQ, 32'h03);
    apb(1'b0, `DCC_OFS_REQ, 0);
    check(rd, 32'hF4);
    // channel 2 is in block mode: it keeps transferring until end_of_block
    s = n_step;
    apb(1'b1, `DCC_OFS_CMD, 32'h08);
    wait_cyc(60);
    check(n_step - s > 4, 1'b1);
    eob <= 1'b1;
    wait_cyc(10);
    check(dack, 4'hF);
    check(n_mrd != 0 && n_iow != 0, 1'b1);
    drain();
    apb(1'b1, `DCC_OFS_MASK, 32'hF9);
    apb(1'b0, `DCC_OFS_MASK, 0);
    check(rd, 32'hFD);
    apb(1'b1, `DCC_OFS_MASK, 32'h05);
    apb(1'b0, `DCC_OFS_MASK, 0);
    check(rd, 32'hFF);
    apb(1'b0, 8'h30, 0);
    check(err, 1'b1);
  endtask
  task automatic t_tick();
    int s;
    for (int d = 0; d < 2; d++) begin
      apb(1'b1, `DCC_OFS_CFG, d);
      wait_cyc(4);
      s = n_tick;
      wait_cyc(20);
      check(n_tick - s, d ? 20 : 10);
    end
  endtask
  task automatic t_service();
    prog_mode(8'h45, 8'h08);
    apb(1'b1, `DCC_OFS_MASK, 32'h04);
    apb(1'b1, `DCC_OFS_MASK, 32'h01);
    serve(1, 4'hD, 4'hF);
    check(t_wr - t_rd, 1);
    check(st_dec, 1'b0);
    prog_mode(8'h75, 8'h28);
    serve(1, 4'hD, 4'hF);
    check(t_wr - t_rd, 0);
    check(st_dec, 1'b1);
    check(st_auto, 1'b1);
    // polarity flips only while the controller is disabled
    apb(1'b1, `DCC_OFS_CMD, 32'hCC);
    pol_hi <= 1'b1;
    apb(1'b1, `DCC_OFS_CMD, 32'hC8);
    check(dack, 4'h0);
    serve(1, 4'h2, 4'h0);
    apb(1'b1, `DCC_OFS_CMD, 32'hCC);
    pol_hi <= 1'b0;
    apb(1'b1, `DCC_OFS_CMD, 32'h08);
  endtask
  task automatic t_timing();
    prog_mode(8'h45, 8'h00);
    serve(1, 4'hD, 4'hF);
    check(t_wr - t_rd, 0);
    check(t_rd_end - t_rd, 1);
    prog_mode(8'h45, 8'h08);
    apb(1'b1, `DCC_OFS_CFG, 32'h09);
    serve(1, 4'hD, 4'hF);
    check(t_rd_end - t_rd, 4);
    stall <= 1'b1;
    apb(1'b1, `DCC_OFS_CFG, 32'h01);
    serve(1, 4'hD, 4'hF);
    check(t_rd_end - t_rd, 5);
    stall <= 1'b0;
  endtask
  task automatic t_block();
    apb(1'b1, `DCC_OFS_MASK, 32'h05);
    want[1] <= 1'b1;
    wait_cyc(20);
    check(dack, 4'hF);
    apb(1'b1, `DCC_OFS_CMD, 32'h0C);
    apb(1'b1, `DCC_OFS_MASK, 32'h01);
    wait_cyc(20);
    check(dack, 4'hF);
    want[1] <= 1'b0;
    wait_cyc(2);
    apb(1'b1, `DCC_OFS_CMD, 32'h08);
  endtask
  task automatic t_priority();
    int k;
    prog_mode(8'h44, 8'h08);
    prog_mode(8'h46, 8'h0C);
    // pass 0 fixed priority; pass 1 rotating after channel 0 was served last
    for (int r = 0; r < 2; r++) begin
      apb(1'b1, `DCC_OFS_REQ, 32'h06);
      apb(1'b1, `DCC_OFS_REQ, 32'h04);
      apb(1'b1, `DCC_OFS_CMD, r ? 32'h18 : 32'h08);
      k = 0;
      while (dack === 4'hF && k < 60) begin @(posedge pclk); k++; end
      check(dack, r ? 4'hB : 4'hE);
      drain();
      apb(1'b1, `DCC_OFS_CMD, 32'h1C);
      if (r == 0) begin
        apb(1'b1, `DCC_OFS_REQ, 32'h04);
        apb(1'b1, `DCC_OFS_CMD, 32'h18);
        drain();
        apb(1'b1, `DCC_OFS_CMD, 32'h1C);
      end
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    wait_cyc(8);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_tick();
    t_service();
    t_timing();
    t_block();
    t_priority();
    report_and_stop();
  end
endmodule
